// >>> adcphi_top.sv
`timescale 1ns/1ps
`include "adcphi_cfg.svh"
// Operation
// RULE_01 - sixteen-bit three-state data bus steered by select and read/write
// RULE_02 - read/write low with chip select low is a read; device drives data
// RULE_03 - read/write high with chip select low is a write; device captures bus
// RULE_04 - one low ready pulse, half an internal clock period, per result; the code holds it low for one whole system clock
// RULE_05 - reset falling edge clears digital logic and powers the part down; the code clears the filter and result but keeps the write word o_wr_word
// RULE_06 - while reset stays low the device stays in reset
// RULE_07 - sync falling edge restarts the decimation filter
// RULE_08 - host supplies a clean master clock; output rate scales with it
// RULE_09 - modulator gives one word per internal clock to the filter
// RULE_10 - bus driven only during selected read, released otherwise
module adcphi_top
    import adcphi_pkg::*;
#(
    parameter int DECIM = `ADCPHI_DECIM_DFLT
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_cs_n,
    input wire logic i_rd_wr,
    input wire logic i_reset_pin_n,
    input wire logic i_sync_n,
    input wire logic [15:0] i_mod_word,
    input wire logic [15:0] i_bus,
    output logic [15:0] o_bus,
    output logic [15:0] o_bus_oe_n,
    output logic o_result_ready_strobe_n,
    output logic o_powered_down,
    output logic [15:0] o_wr_word
);
    // three-stage synchronisers for pin inputs
    logic [2:0] cs_s_ff;
    logic [2:0] rw_s_ff;
    logic [2:0] rst_s_ff;
    logic [2:0] sy_s_ff;
    logic cs_q_ff;
    logic rw_q_ff;
    logic rst_q_ff;
    logic sy_q_ff;
    logic wr_prev_ff;
    // stages two and three agree: the level is safe to take
    function automatic logic stable_pair(input logic [2:0] s);
        return s[1] == s[2];
    endfunction
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cs_s_ff <= 3'h7;
            rw_s_ff <= 3'h0;
            rst_s_ff <= 3'h0;
            sy_s_ff <= 3'h7;
        end else begin
            cs_s_ff <= {cs_s_ff[1:0], i_cs_n};
            rw_s_ff <= {rw_s_ff[1:0], i_rd_wr};
            rst_s_ff <= {rst_s_ff[1:0], i_reset_pin_n};
            sy_s_ff <= {sy_s_ff[1:0], i_sync_n};
        end
    end
    // a level counts once stages two and three agree
    wire cs_take = stable_pair(cs_s_ff);
    wire rw_take = stable_pair(rw_s_ff);
    wire rst_take = stable_pair(rst_s_ff);
    wire sy_take = stable_pair(sy_s_ff);
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cs_q_ff <= 1'b1;
            rw_q_ff <= 1'b0;
            rst_q_ff <= 1'b0;
            sy_q_ff <= 1'b1;
        end else begin
            if (cs_take) cs_q_ff <= cs_s_ff[2];
            if (rw_take) rw_q_ff <= rw_s_ff[2];
            if (rst_take) rst_q_ff <= rst_s_ff[2];
            if (sy_take) sy_q_ff <= sy_s_ff[2];
        end
    end
    wire cs_n_q = cs_q_ff;
    wire rw_q = rw_q_ff;
    wire rst_q = rst_q_ff;
    // edge taken from the qualified level so a pin glitch never counts
    wire sync_fall = sy_q_ff && sy_take && !sy_s_ff[2]; // RULE_07
    wire rd_sel = !cs_n_q && !rw_q; // RULE_02
    wire wr_sel = !cs_n_q && rw_q; // RULE_03
    // one capture per access: the host data has settled by then
    wire wr_start = wr_sel && !wr_prev_ff; // RULE_03
    adcphi_state_t st_ff, nxt_st;
    // pin low keeps the part down; release restarts from a clean state
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ADCPHI_ST_DOWN: if (rst_q) nxt_st = ADCPHI_ST_RUN; // RULE_06
            ADCPHI_ST_RUN: if (!rst_q) nxt_st = ADCPHI_ST_DOWN; // RULE_05
            default: nxt_st = ADCPHI_ST_DOWN;
        endcase
    end
    wire running = (st_ff == ADCPHI_ST_RUN) && rst_q;
    localparam int CW = $clog2(DECIM);
    logic [CW-1:0] dec_cnt_ff;
    logic [19:0] acc_ff;
    logic [15:0] res_ff;
    logic [15:0] wr_ff;
    logic result_ready_strobe_n_ff;
    wire dec_last = (dec_cnt_ff == CW'(DECIM - 1));
    wire [19:0] acc_sum = acc_ff + {4'h0, i_mod_word};
    // a restart or a power-down throws away the partial sum
    wire dec_clear = !running || sync_fall; // RULE_05 RULE_07
    wire dec_dump = running && !sync_fall && dec_last; // RULE_09
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= ADCPHI_ST_DOWN;
            wr_prev_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            wr_prev_ff <= wr_sel;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dec_cnt_ff <= '0;
            acc_ff <= `ADCPHI_ACC_RST;
        end else if (dec_clear || dec_dump) begin
            dec_cnt_ff <= '0;
            acc_ff <= `ADCPHI_ACC_RST;
        end else begin
            dec_cnt_ff <= dec_cnt_ff + 1'b1;
            acc_ff <= acc_sum;
        end
    end
    // the result is a 16-bit view of the sum; low bits are dropped
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            res_ff <= `ADCPHI_RES_RST;
        end else if (!running) begin
            res_ff <= `ADCPHI_RES_RST; // RULE_05
        end else if (dec_dump) begin
            res_ff <= acc_sum[19:4]; // RULE_09
        end
    end
    // a whole system clock stands in for the half-period pulse
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            result_ready_strobe_n_ff <= 1'b1;
        end else begin
            result_ready_strobe_n_ff <= !dec_dump; // RULE_04
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ff <= `ADCPHI_RES_RST;
        end else if (running && wr_start) begin
            wr_ff <= i_bus; // RULE_03
        end
    end
    // drive only on a selected read so the host never contends
    wire bus_drive = rd_sel && running; // RULE_10
    assign o_bus_oe_n = bus_drive ? 16'h0000 : 16'hFFFF; // RULE_01
    assign o_bus = res_ff; // RULE_02
    assign o_result_ready_strobe_n = result_ready_strobe_n_ff; // RULE_04
    assign o_powered_down = !running; // RULE_05
    assign o_wr_word = wr_ff;
    chk_bus_release: assert property (@(posedge i_sys_clk) // RULE_10
        disable iff (!i_rstn) !bus_drive |-> o_bus_oe_n == 16'hFFFF)
        else $error("bus driven outside a read");
    chk_read_drive: assert property (@(posedge i_sys_clk) // RULE_02
        disable iff (!i_rstn) rd_sel && running |-> o_bus_oe_n == 16'h0000)
        else $error("read not driven");
    chk_strobe_one: assert property (@(posedge i_sys_clk) // RULE_04
        disable iff (!i_rstn) !o_result_ready_strobe_n |=> o_result_ready_strobe_n)
        else $error("strobe too long");
    chk_down_quiet: assert property (@(posedge i_sys_clk) // RULE_06
        disable iff (!i_rstn) !rst_q |=> o_result_ready_strobe_n && o_powered_down)
        else $error("active in reset");
    chk_down_clear: assert property (@(posedge i_sys_clk) // RULE_05
        disable iff (!i_rstn) $fell(rst_q) |=> res_ff == 16'h0000)
        else $error("result not cleared");
    chk_sync_rst: assert property (@(posedge i_sys_clk) // RULE_07
        disable iff (!i_rstn) sync_fall |=> dec_cnt_ff == '0 && acc_ff == '0)
        else $error("sync ignored");
    chk_rate: assert property (@(posedge i_sys_clk) // RULE_09
        disable iff (!i_rstn) running && !sync_fall && !dec_last
        |=> dec_cnt_ff == $past(dec_cnt_ff) + 1'b1) else $error("rate");
    chk_write_cap: assert property (@(posedge i_sys_clk) // RULE_03
        disable iff (!i_rstn) running && wr_start |=> o_wr_word == $past(i_bus))
        else $error("write not captured");
    chk_write_once: assert property (@(posedge i_sys_clk) // RULE_03
        disable iff (!i_rstn) wr_prev_ff && wr_sel |=> $stable(o_wr_word))
        else $error("write captured twice");
    chk_oe_whole: assert property (@(posedge i_sys_clk) // RULE_01
        disable iff (!i_rstn) o_bus_oe_n == 16'h0000 || o_bus_oe_n == 16'hFFFF)
        else $error("bus split");
    chk_down_state: assert property (@(posedge i_sys_clk) // RULE_06
        disable iff (!i_rstn) !rst_q |=> st_ff == ADCPHI_ST_DOWN)
        else $error("left reset state");
    chk_strobe_gap: assert property (@(posedge i_sys_clk) // RULE_04
        disable iff (!i_rstn) !o_result_ready_strobe_n
        |=> o_result_ready_strobe_n [*7]) else $error("strobes too close");
    chk_pd_bus: assert property (@(posedge i_sys_clk) // RULE_10
        disable iff (!i_rstn) o_powered_down |-> o_bus_oe_n == 16'hFFFF)
        else $error("bus driven while down");
    chk_pd_result: assert property (@(posedge i_sys_clk) // RULE_05
        disable iff (!i_rstn) o_powered_down && $past(o_powered_down)
        |-> o_bus == 16'h0000) else $error("result kept while down");
    chk_sync_once: assert property (@(posedge i_sys_clk) // RULE_07
        disable iff (!i_rstn) sync_fall |=> !sync_fall)
        else $error("sync edge repeated");
    chk_run_entry: assert property (@(posedge i_sys_clk) // RULE_06
        disable iff (!i_rstn) st_ff == ADCPHI_ST_DOWN && !rst_q |=> o_powered_down)
        else $error("ran with pin low");
    chk_cnt_range: assert property (@(posedge i_sys_clk) // RULE_09
        disable iff (!i_rstn) dec_cnt_ff <= CW'(DECIM - 1))
        else $error("count out of range");
    chk_wr_refused: assert property (@(posedge i_sys_clk) // RULE_06
        disable iff (!i_rstn) o_powered_down |=> $stable(o_wr_word))
        else $error("write taken while down");
    chk_strobe_run: assert property (@(posedge i_sys_clk) // RULE_04
        disable iff (!i_rstn) !o_result_ready_strobe_n |-> $past(running))
        else $error("strobe while down");
    // covers show the main scenarios were reached
    cov_pin_down: cover property (@(posedge i_sys_clk) $fell(rst_q) && running);
    cov_read: cover property (@(posedge i_sys_clk) rd_sel && running);
    cov_write: cover property (@(posedge i_sys_clk) wr_sel && running);
    cov_strobe: cover property (@(posedge i_sys_clk) !o_result_ready_strobe_n);
    cov_sync: cover property (@(posedge i_sys_clk) sync_fall && running);
endmodule

// >>> adcphi_cfg.svh
`ifndef ADCPHI_CFG_SVH
`define ADCPHI_CFG_SVH
`define ADCPHI_BUS_W 16
`define ADCPHI_DIV_RST 4'h0
`define ADCPHI_DECIM_DFLT 8
// value is arbitrary, not tied to any part
`define ADCPHI_ID_WORD 16'ha55a
`define ADCPHI_ACC_RST 20'h0_0000
`define ADCPHI_RES_RST 16'h0000
`endif

// >>> adcphi_pkg.sv
package adcphi_pkg;
    typedef enum logic [1:0] {
        ADCPHI_ST_DOWN,
        ADCPHI_ST_RUN
    } adcphi_state_t;
endpackage

// >>> adcphi_host_model.sv
`timescale 1ns/1ps
module adcphi_host_model (
    input wire logic i_sys_clk,
    input wire logic i_cs_n,
    input wire logic i_rd_wr,
    input wire logic [15:0] i_wdat,
    input wire logic [15:0] i_dev_bus,
    input wire logic [15:0] i_dev_oe_n,
    output logic [15:0] o_bus
);
    logic [15:0] last_ff = 16'h0000;
    logic host_drv;
    assign host_drv = !i_cs_n && i_rd_wr;
    always @(posedge i_sys_clk) last_ff <= o_bus;
    // an undriven bit flips each cycle so a stale word never passes
    always_comb begin
        for (int b = 0; b < 16; b++) begin
            o_bus[b] = !i_dev_oe_n[b] ? i_dev_bus[b] :
                host_drv ? i_wdat[b] : ~last_ff[b];
        end
    end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
    logic i_sys_clk = 0, i_rstn = 0, i_cs_n = 1, i_rd_wr = 0;
    logic i_reset_pin_n = 1, i_sync_n = 1, o_result_ready_strobe_n;
    logic o_powered_down;
    logic [15:0] i_mod_word = 16'h0010, wdat = 16'h0000;
    logic [15:0] i_bus, o_bus, o_bus_oe_n, o_wr_word;
    int n_fail = 0, samples_checked = 0, k;
    always #2.5 i_sys_clk = ~i_sys_clk;
    adcphi_top adcphi_top_i (.i_sys_clk, .i_rstn, .i_cs_n, .i_rd_wr,
        .i_reset_pin_n, .i_sync_n, .i_mod_word, .i_bus, .o_bus,
        .o_bus_oe_n, .o_result_ready_strobe_n, .o_powered_down, .o_wr_word);
    adcphi_host_model adcphi_host_model_i (.i_sys_clk, .i_cs_n, .i_rd_wr,
        .i_wdat(wdat), .i_dev_bus(o_bus), .i_dev_oe_n(o_bus_oe_n),
        .o_bus(i_bus));
    task complete_run;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick; @(posedge i_sys_clk); #1; k++;
        if (k > 60) begin cmp(16'h0bad, 16'h0000); complete_run; end
    endtask
    task t_read; // strobe spacing and decimated word on a selected read
        real t0;
        @(posedge i_sys_clk); i_cs_n <= 0; i_rd_wr <= 0;
        k = 0; while (o_bus_oe_n !== 16'h0000) tick;
        cmp(o_bus_oe_n, 16'h0000);
        k = 0; while (o_result_ready_strobe_n !== 1'b0) tick;
        t0 = $realtime; tick;
        cmp({15'h0, o_result_ready_strobe_n}, 16'h0001);
        k = 0; while (o_result_ready_strobe_n !== 1'b0) tick;
        cmp(16'(int'(($realtime - t0) / 5.0)), 16'h0008);
        tick; cmp(i_bus, 16'h0008);
        @(posedge i_sys_clk); i_cs_n <= 1;
        repeat (4) @(posedge i_sys_clk);
    endtask
    task t_write; // host drives, device must stay off the bus
        @(posedge i_sys_clk); wdat <= 16'h1234; i_cs_n <= 0; i_rd_wr <= 1;
        k = 0; while (o_wr_word !== 16'h1234) tick;
        cmp(o_wr_word, 16'h1234);
        cmp(o_bus_oe_n, 16'hffff);
        @(posedge i_sys_clk); i_cs_n <= 1; i_rd_wr <= 0;
        repeat (4) @(posedge i_sys_clk);
    endtask
    task t_sync; // a sync edge restarts the count, so the next result is late
        real t0;
        k = 0; while (o_result_ready_strobe_n !== 1'b0) tick;
        t0 = $realtime;
        repeat (2) @(posedge i_sys_clk);
        i_sync_n <= 0;
        k = 0; while (o_result_ready_strobe_n !== 1'b1) tick;
        k = 0; while (o_result_ready_strobe_n !== 1'b0) tick;
        cmp(16'(int'(($realtime - t0) / 5.0)), 16'h000e);
        cmp(o_bus, 16'h0008);
        @(posedge i_sys_clk); i_sync_n <= 1;
        repeat (4) @(posedge i_sys_clk);
    endtask
    task t_pin_reset; // a read held while the pin is low is refused
        @(posedge i_sys_clk); i_reset_pin_n <= 0; i_cs_n <= 0;
        k = 0; while (o_powered_down !== 1'b1) tick;
        cmp({15'h0, o_powered_down}, 16'h0001);
        repeat (20) @(posedge i_sys_clk); #1;
        cmp(o_bus_oe_n, 16'hffff);
    endtask
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rstn <= 1;
        #1;
        cmp({o_powered_down, o_bus_oe_n[14:0]}, 16'hffff);
        k = 0; while (o_powered_down !== 1'b0) tick;
        t_read;
        t_write;
        t_sync;
        t_pin_reset;
        complete_run;
    end
endmodule
